// *** common/mfx_pkg.sv ***
// mfx_pkg: encodings, status bit positions and constants for the
// multifunction instruction decode and execute block.
// assumes 24-bit instruction words and 16-bit data registers.
package mfx_pkg;
  // ==========================================================
  // opcode match patterns
  localparam logic [4:0] OP_ALU_DM = 5'h0C; // 0,1,1,G,0 with G=0
  localparam logic [4:0] OP_ALU_DM_MSK = 5'h1D;
  localparam logic [4:0] OP_ALU_PM = 5'h0A;
  localparam logic [6:0] OP_SH_DM = 7'h09; // 0001001, G follows
  localparam logic [8:0] OP_SH_PM = 9'h022;
  localparam logic [4:0] OP_ALU_RR = 5'h05; // 00101
  localparam logic [8:0] OP_SH_RR = 9'h020;
  // ==========================================================
  // status bit positions
  localparam int ST_AZ = 0;
  localparam int ST_AN = 1;
  localparam int ST_AV = 2;
  localparam int ST_AC = 3;
  localparam int ST_AS = 4;
  localparam int ST_MV = 6;
  localparam int ST_SS = 7;
  localparam logic [7:0] ST_RESET = 8'h00;
  // ==========================================================
  // function field codes
  localparam logic [4:0] AMF_ABS = 5'h1F;
  localparam logic [3:0] SF_EXP = 4'hC;
  localparam int NREG = 16;
  typedef enum logic [1:0] {
    MFX_NONE = 2'h0, MFX_ALU = 2'h1, MFX_MAC = 2'h3, MFX_SHF = 2'h2
  } mfx_unit_t;
endpackage

// *** src/mfx_exec.sv ***
// mfx_exec: decodes and executes multifunction instructions in one cycle.
// assumes an instruction word arrives each cycle from program memory and
// memory read data is valid in the same cycle as the address.
//
// Contract
// RQ1: sources sampled at cycle start, all destinations written at cycle end
// RQ2: a register used as source and destination gives old value, new at end
// RQ3: program never names one register as destination of both clauses
// RQ4: computation is unconditional; no condition field is decoded
// RQ5: no immediate shifts or divide steps appear in these forms
// RQ6: behaviour depends only on encoded fields, not clause order
// RQ7: register move copies source into destination right-justified
// RQ8: bits 23:19 = 0,1,1,G,0 decode ALU/MAC with data memory read
// RQ9: bits 23:19 = 01010 decode ALU/MAC with program memory read
// RQ10: bits 23:17 = 0001001, bit 15 zero decode shift with data read
// RQ11: bits 23:15 = 000100010 decode shift with program memory read
// RQ12: status updates match the equivalent single-function operation
// RQ13: ALU updates status bits 4..0 only
// RQ14: shifter changes only bit 7, and only for exponent derive
// RQ15: MAC changes only bit 6, set on overflow of low 32 bits
// RQ16: with latch mode, ALU overflow flag holds until written zero
// RQ17: every form completes in one cycle with no stall
`timescale 1ns/1ps
module mfx_exec
  import mfx_pkg::*;
#(
  parameter int DW = 16
) (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic SRST,
  // instruction word
  input wire logic [23:0] INSTR,
  input wire logic INSTR_VALID,
  // memory access via address generators
  output logic MEM_RD,
  output logic MEM_PM,
  output logic MEM_DAG,
  output logic [1:0] MEM_IDX,
  output logic [1:0] MEM_MOD,
  input wire logic [DW-1:0] MEM_RDATA,
  // mode and status access
  input wire logic OVERFLOW_LATCH_MODE,
  input wire logic STAT_WE,
  input wire logic [7:0] STAT_WDATA,
  output logic [7:0] ARITH_STATUS_FLAGS,
  // register file observation
  input wire logic [3:0] REG_SEL,
  output logic [DW-1:0] REG_RDATA,
  output logic [DW-1:0] RESULT
);
  // ==========================================================
  // decode
  wire is_alu_dm = ((INSTR[23:19] & OP_ALU_DM_MSK) == OP_ALU_DM); // RQ8
  wire is_alu_pm = (INSTR[23:19] == OP_ALU_PM); // RQ9
  wire is_sh_dm = (INSTR[23:17] == OP_SH_DM) && !INSTR[15]; // RQ10
  wire is_sh_pm = (INSTR[23:15] == OP_SH_PM); // RQ11
  wire is_alu_rr = (INSTR[23:19] == OP_ALU_RR);
  wire is_sh_rr = (INSTR[23:15] == OP_SH_RR);
  wire is_alu = is_alu_dm | is_alu_pm | is_alu_rr;
  wire is_sh = is_sh_dm | is_sh_pm | is_sh_rr;
  wire is_rd = is_alu_dm | is_alu_pm | is_sh_dm | is_sh_pm;
  wire is_rr = is_alu_rr | is_sh_rr;
  wire go = INSTR_VALID & (is_alu | is_sh); // RQ4 RQ17
  // alu/mac function: codes with bit 4 clear go to the multiplier
  wire [4:0] alu_mac_function_field = INSTR[17:13];
  wire [3:0] sf = INSTR[14:11];
  wire is_mac = is_alu & !alu_mac_function_field[4];
  wire [2:0] xop = INSTR[10:8];
  wire [1:0] yop = INSTR[12:11];
  wire [3:0] dreg = INSTR[7:4];
  wire [3:0] sreg = INSTR[3:0];
  mfx_unit_t unit;
  assign unit = !go ? MFX_NONE : is_sh ? MFX_SHF : is_mac ? MFX_MAC
              : MFX_ALU;
  // address generator selection
  assign MEM_RD = go & is_rd;
  assign MEM_PM = is_alu_pm | is_sh_pm;
  assign MEM_DAG = is_alu_dm ? INSTR[20] : is_sh_dm ? INSTR[16]
                 : MEM_PM;
  assign MEM_IDX = INSTR[3:2];
  assign MEM_MOD = INSTR[1:0];
  // ==========================================================
  // register file, read at cycle start, written at the edge
  logic [DW-1:0] rf_r [NREG];
  logic [31:0] mr_r;
  logic [7:0] stat_r;
  wire [DW-1:0] xv = rf_r[{1'b0, xop}]; // RQ1 RQ2
  wire [DW-1:0] yv = rf_r[{2'b10, yop}];
  // alu path: add or subtract, abs when selected
  wire [DW:0] sum = alu_mac_function_field[0] ? {1'b0, xv} - {1'b0, yv}
                           : {1'b0, xv} + {1'b0, yv};
  wire [DW-1:0] absv = xv[DW-1] ? DW'(-xv) : xv;
  wire use_abs = (alu_mac_function_field == AMF_ABS);
  wire [DW-1:0] alu_res = use_abs ? absv : sum[DW-1:0];
  wire alu_ov = use_abs ? (xv == {1'b1, {(DW-1){1'b0}}})
              : (alu_mac_function_field[0] ? (xv[DW-1] != yv[DW-1])
                        : (xv[DW-1] == yv[DW-1]))
                && (sum[DW-1] != xv[DW-1]);
  // mac path: accumulate signed product into a 32-bit result
  wire signed [31:0] prod = $signed(xv) * $signed(yv);
  wire signed [32:0] acc = $signed({mr_r[31], mr_r}) + 33'(prod);
  wire mac_ov = acc[32] != acc[31];
  // shifter: exponent derive counts redundant sign bits
  logic [DW-1:0] expv;
  logic exp_hit;
  // the hit flag freezes the count at the first bit unlike the sign,
  // since a count of zero is itself a valid answer
  always_comb begin
    expv = '0;
    exp_hit = 1'b0;
    for (int i = DW - 2; i >= 0; i--) begin
      if (xv[i] != xv[DW-1] && !exp_hit) begin
        expv = DW'(DW - 2 - i);
        exp_hit = 1'b1;
      end
    end
  end
  wire [DW-1:0] sh_res = (sf == SF_EXP) ? expv : DW'(xv << sf[1:0]);
  // ==========================================================
  // status next value
  logic [7:0] st_nxt;
  always_comb begin
    st_nxt = STAT_WE ? STAT_WDATA : stat_r;
    case (unit)
      MFX_ALU: begin // RQ12 RQ13
        st_nxt[ST_AZ] = (alu_res == '0);
        st_nxt[ST_AN] = alu_res[DW-1];
        st_nxt[ST_AV] = alu_ov | (OVERFLOW_LATCH_MODE & stat_r[ST_AV]
                        & !(STAT_WE & !STAT_WDATA[ST_AV])); // RQ16
        st_nxt[ST_AC] = use_abs ? 1'b0 : sum[DW];
        if (use_abs) begin
          st_nxt[ST_AS] = xv[DW-1];
        end
      end
      MFX_MAC: st_nxt[ST_MV] = mac_ov; // RQ15
      MFX_SHF: begin
        if (sf == SF_EXP) begin
          st_nxt[ST_SS] = xv[DW-1]; // RQ14
        end
      end
      default: ;
    endcase
  end
  // ==========================================================
  // destination writes, both at the same edge
  wire [DW-1:0] cres = is_sh ? sh_res : alu_res;
  wire [3:0] cdst = INSTR[18] ? 4'hD : 4'hC;
  wire [DW-1:0] xfer = is_rr ? rf_r[sreg] : MEM_RDATA; // RQ7 RQ6
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      stat_r <= ST_RESET;
      mr_r <= '0;
      RESULT <= '0;
      for (int i = 0; i < NREG; i++) begin
        rf_r[i] <= '0;
      end
    end else begin
      stat_r <= st_nxt;
      if (go) begin
        if (is_mac) begin
          mr_r <= acc[31:0];
        end else begin
          rf_r[cdst] <= cres; // RQ1
        end
        RESULT <= is_mac ? acc[DW-1:0] : cres;
        rf_r[dreg] <= xfer; // RQ2 RQ3
      end
    end
  end
  assign ARITH_STATUS_FLAGS = stat_r;
  assign REG_RDATA = rf_r[REG_SEL];
  // ==========================================================
  // checks
  chk_alu_keeps_upper: assert property (@(posedge CORE_CLK) // RQ13
    disable iff (SRST) (unit == MFX_ALU && !STAT_WE) |=>
    stat_r[7:5] == $past(stat_r[7:5]))
    else $error("alu changed upper status bits");
  chk_mac_only_mv: assert property (@(posedge CORE_CLK) // RQ15
    disable iff (SRST) (unit == MFX_MAC && !STAT_WE) |=>
    stat_r[ST_MV] == $past(mac_ov)
    && {stat_r[7], stat_r[5:0]} == $past({stat_r[7], stat_r[5:0]}))
    else $error("mac status update wrong");
  chk_shift_ss_only: assert property (@(posedge CORE_CLK) // RQ14
    disable iff (SRST) (unit == MFX_SHF && !STAT_WE) |=>
    stat_r[6:0] == $past(stat_r[6:0]))
    else $error("shift touched other status bits");
  chk_overflow_latch_mode: assert property (@(posedge CORE_CLK) // RQ16
    disable iff (SRST)
    (OVERFLOW_LATCH_MODE && stat_r[ST_AV] && !STAT_WE) |=> stat_r[ST_AV])
    else $error("latched overflow lost");
  chk_move_value: assert property (@(posedge CORE_CLK) // RQ7
    disable iff (SRST) (go && is_rr && dreg != cdst) |=>
    rf_r[$past(dreg)] == $past(rf_r[sreg]))
    else $error("register move value wrong");
  chk_old_source: assert property (@(posedge CORE_CLK) // RQ2
    disable iff (SRST) (go && !is_mac && MEM_RD && dreg != cdst) |=>
    rf_r[$past(cdst)] == $past(cres))
    else $error("computation did not use old value");
  chk_dm_decode: assert property (@(posedge CORE_CLK) // RQ8
    disable iff (SRST) (INSTR_VALID && INSTR[23:19] == 5'h0E) |->
    MEM_RD && !MEM_PM && MEM_DAG)
    else $error("data read decode wrong");
  chk_pm_decode: assert property (@(posedge CORE_CLK) // RQ9 RQ11
    disable iff (SRST) (INSTR_VALID && (INSTR[23:19] == 5'h0A
    || INSTR[23:15] == 9'h022)) |-> MEM_RD && MEM_PM)
    else $error("program read decode wrong");
  chk_sh_dm: assert property (@(posedge CORE_CLK) // RQ10
    disable iff (SRST) (INSTR_VALID && INSTR[23:17] == 7'h09
    && !INSTR[15]) |-> MEM_RD && !MEM_PM && MEM_DAG == INSTR[16])
    else $error("shift data read decode wrong");
  // a read lands in its destination at the same edge as the computation
  chk_read_lands: assert property (@(posedge CORE_CLK) // RQ1
    disable iff (SRST) (MEM_RD && dreg != cdst) |=>
    rf_r[$past(dreg)] == $past(MEM_RDATA))
    else $error("memory word not written to destination");
  chk_idle_quiet: assert property (@(posedge CORE_CLK) // RQ17
    disable iff (SRST) (!go && !STAT_WE) |=>
    stat_r == $past(stat_r))
    else $error("status moved with no instruction");
  chk_result_reg: assert property (@(posedge CORE_CLK) // RQ8
    disable iff (SRST) (go && !is_mac && !is_sh && dreg != cdst) |=>
    rf_r[$past(INSTR[18]) ? 4'hD : 4'hC] == RESULT)
    else $error("result register select wrong");
endmodule

// *** verif/mfx_mem_model.sv ***
// mfx_mem_model: data and program memory seen through the address
// generators; answers in the same cycle as the read strobe.
// assumes a combinational read path, contents fixed at build time.
`timescale 1ns/1ps
module mfx_mem_model (
  // clock
  input wire logic CORE_CLK,
  // read request
  input wire logic MEM_RD,
  input wire logic MEM_PM,
  input wire logic [1:0] MEM_IDX,
  // read answer
  output logic [15:0] MEM_RDATA
);
  // ==========================================================
  // contents and release
  logic [63:0] dm_img = {16'h0005, 16'h8000, 16'h0001, 16'h7FFF};
  logic [63:0] pm_img = {16'h0F0F, 16'h8000, 16'h1234, 16'h5555};
  logic [15:0] word;
  logic [15:0] last_r = 16'h0000;
  // a released bus shows inverted old data, so stale reads cannot pass
  assign word = MEM_PM ? pm_img[MEM_IDX*16 +: 16] : dm_img[MEM_IDX*16 +: 16];
  assign MEM_RDATA = MEM_RD ? word : ~last_r;
  always_ff @(posedge CORE_CLK) begin
    if (MEM_RD) begin
      last_r <= word;
    end
  end
endmodule

// *** verif/tb_multifunction_instruction_exec.sv ***
// tb_multifunction_instruction_exec: runs each multifunction form and
// compares registers, status and memory strobes with worked-out values.
// assumes mfx_exec and mfx_mem_model; inputs change at falling edges.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin \
  mismatches++; $display("ERROR %s exp %h got %h", nm, e, g); end end
module tb_multifunction_instruction_exec;
  import mfx_pkg::*;
  // ==========================================================
  // stimulus and observation
  logic clk = 0, srst = 1, vld = 0, olm = 0, swe = 0;
  logic [23:0] ins = 24'h000000;
  logic [7:0] swd = 8'h00;
  logic [3:0] rsel = 4'h0;
  logic rd, pm, dag;
  logic [1:0] idx, mdf;
  logic [15:0] rdat, rview, res;
  logic [7:0] st;
  // unconditional mac on zero regs keeps the status quiet during loads
  logic [10:0] macz = {1'b0, 5'h00, 2'h1, 3'h2};
  int mismatches = 0, checked = 0, cyc = 0;
  mfx_exec dut (.CORE_CLK(clk), .SRST(srst), .INSTR(ins),
    .INSTR_VALID(vld), .MEM_RD(rd), .MEM_PM(pm), .MEM_DAG(dag),
    .MEM_IDX(idx), .MEM_MOD(mdf), .MEM_RDATA(rdat),
    .OVERFLOW_LATCH_MODE(olm), .STAT_WE(swe), .STAT_WDATA(swd),
    .ARITH_STATUS_FLAGS(st), .REG_SEL(rsel), .REG_RDATA(rview),
    .RESULT(res));
  mfx_mem_model mem (.CORE_CLK(clk), .MEM_RD(rd), .MEM_PM(pm),
    .MEM_IDX(idx), .MEM_RDATA(rdat));
  initial begin
    forever #4 clk = ~clk;
  end
  // ==========================================================
  // access tasks
  task automatic run(input logic [23:0] w);
    @(negedge clk);
    ins = w;
    vld = 1;
    #1;
  endtask
  task automatic idle();
    @(negedge clk);
    vld = 0;
    #1;
  endtask
  task automatic reg_is(input logic [3:0] r, input logic [15:0] e);
    rsel = r;
    #1;
    `CHK("reg", e, rview)
  endtask
  task automatic report_and_stop();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // ==========================================================
  // hang guard: the whole sequence needs well under 100 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      mismatches++;
      report_and_stop();
    end
  end
  // ==========================================================
  // scenarios; no form names one destination twice
  initial begin
    repeat (5) @(posedge clk);
    @(negedge clk);
    srst = 0;
    `CHK("status", 8'h00, st)
    run({3'h3, 1'b1, 1'b0, macz, 4'h0, 2'h0, 2'h2});
    `CHK("mem", 7'h52, {rd, pm, dag, idx, mdf})
    run({3'h3, 1'b0, 1'b0, macz, 4'h8, 2'h1, 2'h0});
    `CHK("mem", 7'h44, {rd, pm, dag, idx, mdf})
    run({5'h0A, macz, 4'h1, 2'h2, 2'h3});
    `CHK("mem", 7'h7B, {rd, pm, dag, idx, mdf})
    idle();
    reg_is(4'h0, 16'h7FFF);
    reg_is(4'h8, 16'h0001);
    reg_is(4'h1, 16'h8000);
    `CHK("status", 8'h00, st)
    // add with move that overwrites an operand: old value must be used
    run({5'h05, 1'b0, 5'h10, 2'h0, 3'h0, 4'h0, 4'h8});
    idle();
    reg_is(4'hC, 16'h8000);
    reg_is(4'h0, 16'h0001);
    `CHK("status", 8'h06, st)
    `CHK("result", 16'h8000, res)
    @(negedge clk);
    olm = 1;
    run({5'h05, 1'b0, 5'h10, 2'h0, 3'h0, 4'h2, 4'h3});
    idle();
    reg_is(4'hC, 16'h0002);
    `CHK("status", 8'h04, st)
    @(negedge clk);
    swe = 1;
    @(negedge clk);
    swe = 0;
    #1;
    `CHK("status", 8'h00, st)
    run({7'h09, 1'b0, 1'b0, SF_EXP, 3'h1, 4'h3, 2'h3, 2'h1});
    `CHK("mem", 7'h4D, {rd, pm, dag, idx, mdf})
    idle();
    `CHK("status", 8'h80, st)
    reg_is(4'h3, 16'h0005);
    `CHK("result", 16'h0000, res)
    // shift with register move: no read, sign flag left alone
    run({9'h020, 4'h1, 3'h3, 4'h5, 4'h3});
    `CHK("mem", 1'b0, rd)
    idle();
    `CHK("status", 8'h80, st)
    reg_is(4'h5, 16'h0005);
    `CHK("result", 16'h000A, res)
    run({9'h022, SF_EXP, 3'h3, 4'h4, 2'h1, 2'h0});
    `CHK("mem", 7'h74, {rd, pm, dag, idx, mdf})
    idle();
    `CHK("status", 8'h00, st)
    reg_is(4'h4, 16'h1234);
    `CHK("result", 16'h000C, res)
    // three macs back to back: the move loads the operand, two products
    run({5'h05, 1'b0, 5'h00, 2'h1, 3'h1, 4'h9, 4'h1});
    run({5'h05, 1'b0, 5'h00, 2'h1, 3'h1, 4'h9, 4'h1});
    run({5'h05, 1'b0, 5'h00, 2'h1, 3'h1, 4'h9, 4'h1});
    `CHK("status", 8'h00, st)
    idle();
    `CHK("status", 8'h40, st)
    reg_is(4'h9, 16'h8000);
    // subtract into the second result register keeps the mac flag
    run({5'h05, 1'b1, 5'h11, 2'h0, 3'h1, 4'h6, 4'h6});
    idle();
    `CHK("status", 8'h44, st)
    reg_is(4'hD, 16'h7FFF);
    `CHK("result", 16'h7FFF, res)
    run(24'h000000);
    `CHK("mem", 1'b0, rd)
    idle();
    reg_is(4'hC, 16'h000C);
    report_and_stop();
  end
endmodule
